// >>> core/fsi_pkg.sv
// fsi_pkg: register map, event bit layout and timing constants of the
// fieldbus slave indication unit.
// assumes a 100 MHz system clock and a 32-bit APB register port.
package fsi_pkg;

	// ==========================================================================
	// register map (byte addresses)
	localparam logic [7:0] FSI_PENDING_OFFS = 8'h00;
	localparam logic [7:0] FSI_ENABLE_OFFS  = 8'h04;
	localparam logic [7:0] FSI_ACK_OFFS     = 8'h08;
	localparam logic [7:0] FSI_EOI_OFFS     = 8'h0c;
	localparam logic [7:0] FSI_BIT_OFFS     = 8'h40;
	localparam logic [7:0] FSI_BITACK_OFFS  = 8'h80;
	localparam logic [7:0] FSI_CMD_OFFS     = 8'hc0;

	// ==========================================================================
	// event bit positions in the 16-bit reason field
	localparam int FSI_EV_WIDTH      = 16;
	localparam int FSI_EV_COUNT      = 11;
	localparam int FSI_EV_OFFLINE    = 0;
	localparam int FSI_EV_EXCHANGE   = 1;
	localparam int FSI_EV_RATE       = 2;
	localparam int FSI_EV_WATCHDOG   = 3;
	localparam int FSI_EV_UTIMER     = 4;
	localparam int FSI_EV_GLOBAL_CMD = 8;
	localparam int FSI_EV_ADDRESS    = 9;
	localparam int FSI_EV_CONFIG     = 10;
	localparam int FSI_EV_PARAM      = 11;
	localparam int FSI_EV_DIAG       = 12;
	localparam int FSI_EV_OUTPUT     = 13;
	localparam logic [15:0] FSI_EV_IMPL_MASK = 16'h3f1f;

	// ==========================================================================
	// reset values
	localparam logic [15:0] FSI_ENABLE_RST  = 16'h0000;
	localparam logic [15:0] FSI_PENDING_RST = 16'h2000;
	localparam logic [7:0]  FSI_GCMD_RST    = 8'h00;

	// ==========================================================================
	// timing
	localparam int CLK_FREQ_HZ     = 100_000_000;
	localparam int UTIMER_PERIOD_MS = 10;
	localparam int UTIMER_CYCLES   = CLK_FREQ_HZ / 1000 * UTIMER_PERIOD_MS;
	localparam int UTIMER_W        = 20;

	typedef enum logic [1:0] {
		FSI_IRQ_IDLE = 2'b00,
		FSI_IRQ_ACTIVE = 2'b01,
		FSI_IRQ_WAIT_EOI = 2'b11
	} fsi_irq_state_type;

endpackage

// >>> core/fsi_indication_unit.sv
// fsi_indication_unit: collects slave protocol events into a pending word,
// acknowledge by word or by bit, end-of-interrupt, one interrupt line.
// assumes event inputs are one-cycle pulses from logic on sys_clk_in.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - pending reasons readable as one word
// - single reason readable, 1 when pending
// - exchange event on enter or leave
// - offline request finishes, then offline event
// - rate event on leaving rate search with a valid rate
// - watchdog expiry in master-controlled state raises event
// - user timer tick every 10 ms
// - changed global command stored, event raised
// - address message buffered, event raised
// - configuration message buffered, event raised
// - parameter message buffered, event raised
// - diagnostics swap returns buffer, raises event
// - write-read data buffered, output event
// - power-on or master leave clears, output event
// - per-event acknowledge also accepted
// - interrupt only for enabled events
// - reasons are bits of 16-bit field
module fsi_indication_unit
	import fsi_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        rstn_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [3:0]  pstrb_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        exchange_state_in,
	input  wire logic        offline_req_in,
	input  wire logic        request_busy_in,
	input  wire logic        rate_search_in,
	input  wire logic        rate_valid_in,
	input  wire logic        wd_expired_in,
	input  wire logic        master_controlled_wd_state_in,
	input  wire logic        global_cmd_rx_in,
	input  wire logic [7:0]  global_cmd_byte_in,
	input  wire logic        address_msg_stored_in,
	input  wire logic        config_msg_stored_in,
	input  wire logic        param_msg_stored_in,
	input  wire logic        diag_swap_done_in,
	input  wire logic        output_data_stored_in,
	input  wire logic        master_leave_in,
	output logic             offline_state_out,
	output logic             diag_swap_req_out,
	output logic             output_buf_clear_out,
	output logic      [7:0]  global_cmd_cell_out,
	output logic             irq_out
);

	// ==========================================================================
	// state
	// poweron and pending bit 13 (output) leave reset set: poweron fires the output
	// buffer clear once, so the output event is pending two edges later.
	// a protocol fsm already in exchange state at reset release reads as
	// an entry and raises the exchange event once.
	typedef struct packed {
		logic [15:0]       pending;
		logic [15:0]       enable;
		logic [7:0]        gcmd;
		logic              exch_prev;
		logic              rate_prev;
		logic              offline_wait;
		logic              offline;
		logic              diag_req;
		logic              obuf_clear;
		logic              poweron;
		logic [UTIMER_W-1:0] utimer;
		fsi_irq_state_type irq_st;
		logic [31:0]       rdata;
	} fsi_state_type;

	fsi_state_type st_q;
	fsi_state_type st_d;

	logic        apb_wr;
	logic        apb_rd;
	logic        apb_setup_rd;
	logic [15:0] ev_set;
	logic [15:0] ack_word;
	logic        eoi;
	logic [15:0] wmask;
	logic [3:0]  bit_idx;
	logic        sel_pending;
	logic        sel_enable;
	logic        sel_ack;
	logic        sel_eoi;
	logic        sel_bit;
	logic        sel_bitack;
	logic        sel_cmd;
	logic        irq_want;

	// ==========================================================================
	// register decode
	// pending word, enable word, ack word and eoi come first, then one word
	// per event for single-bit reads, one per event for single-bit acks,
	// then the command word. writes act only at the access edge.
	assign apb_wr       = psel_in & penable_in & pwrite_in;
	assign apb_rd       = psel_in & penable_in & ~pwrite_in;
	assign apb_setup_rd = psel_in & ~penable_in & ~pwrite_in;
	assign bit_idx      = paddr_in[5:2];
	// only byte lanes 0 and 1 carry the 16-bit event fields
	assign wmask        = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
	assign sel_pending  = (paddr_in == FSI_PENDING_OFFS);
	assign sel_enable   = (paddr_in == FSI_ENABLE_OFFS);
	assign sel_ack      = (paddr_in == FSI_ACK_OFFS);
	assign sel_eoi      = (paddr_in == FSI_EOI_OFFS);
	assign sel_bit      = (paddr_in[7:6] == FSI_BIT_OFFS[7:6]);
	assign sel_bitack   = (paddr_in[7:6] == FSI_BITACK_OFFS[7:6]);
	assign sel_cmd      = (paddr_in == FSI_CMD_OFFS);

	// ==========================================================================
	// next state
	always_comb
	begin
		st_d     = st_q;
		ev_set   = '0;
		ack_word = '0;
		eoi      = 1'b0;
		irq_want = 1'b0;

		st_d.exch_prev = exchange_state_in;
		st_d.rate_prev = rate_search_in;
		if (exchange_state_in != st_q.exch_prev)
			ev_set[FSI_EV_EXCHANGE] = 1'b1;

		// offline request waits for the running request to finish
		if (offline_req_in && !st_q.offline)
			st_d.offline_wait = 1'b1;
		if (st_q.offline_wait && !request_busy_in)
		begin
			st_d.offline_wait = 1'b0;
			st_d.offline = 1'b1;
			ev_set[FSI_EV_OFFLINE] = 1'b1;
		end
		if (st_q.rate_prev && !rate_search_in && rate_valid_in)
			ev_set[FSI_EV_RATE] = 1'b1;
		if (wd_expired_in && master_controlled_wd_state_in)
			ev_set[FSI_EV_WATCHDOG] = 1'b1;

		// free-running tick base; it is never reset by software, so the
		// first tick after a host enable may come early
		if (st_q.utimer == UTIMER_W'(UTIMER_CYCLES - 1))
		begin
			st_d.utimer = '0;
			ev_set[FSI_EV_UTIMER] = 1'b1;
		end
		else
			st_d.utimer = st_q.utimer + 1'b1;

		if (global_cmd_rx_in && global_cmd_byte_in != st_q.gcmd)
		begin
			st_d.gcmd = global_cmd_byte_in;
			ev_set[FSI_EV_GLOBAL_CMD] = 1'b1;
		end
		ev_set[FSI_EV_ADDRESS] = address_msg_stored_in;
		ev_set[FSI_EV_CONFIG]  = config_msg_stored_in;
		ev_set[FSI_EV_PARAM]   = param_msg_stored_in;
		if (diag_swap_done_in && st_q.diag_req)
		begin
			st_d.diag_req = 1'b0;
			ev_set[FSI_EV_DIAG] = 1'b1;
		end
		// output event for new data and for buffer clear at power-on or master leave
		st_d.obuf_clear = master_leave_in | st_q.poweron;
		st_d.poweron = 1'b0;
		if (output_data_stored_in || st_q.obuf_clear)
			ev_set[FSI_EV_OUTPUT] = 1'b1;

		// ======================================================================
		// register writes
		if (apb_wr)
		begin
			if (sel_enable)
			begin
				st_d.enable = (st_q.enable & ~wmask)
					| (pwdata_in[15:0] & wmask & FSI_EV_IMPL_MASK);
			end
			else if (sel_ack)
			begin
				ack_word = pwdata_in[15:0] & wmask;
			end
			else if (sel_eoi)
			begin
				eoi = 1'b1;
			end
			else if (sel_bitack)
			begin
				ack_word[bit_idx] = pwdata_in[0];
			end
			else if (sel_cmd)
			begin
				if (pwdata_in[0])
					st_d.offline_wait = 1'b1;
				if (pwdata_in[1])
					st_d.diag_req = 1'b1;
				// going back online loses to an offline entry in the same cycle
				if (pwdata_in[2] && !ev_set[FSI_EV_OFFLINE])
					st_d.offline = 1'b0;
			end
		end
		// set wins over acknowledge in the same cycle
		st_d.pending = ((st_q.pending & ~ack_word) | ev_set) & FSI_EV_IMPL_MASK;

		// ======================================================================
		// interrupt sequencing: line drops on service, returns only after eoi
		irq_want = |(st_d.pending & st_q.enable);
		case (st_q.irq_st)
			FSI_IRQ_IDLE:
			begin
				if (irq_want)
					st_d.irq_st = FSI_IRQ_ACTIVE;
			end
			FSI_IRQ_ACTIVE:
			begin
				// reading the pending word counts as taking the interrupt
				if (apb_rd && sel_pending)
					st_d.irq_st = FSI_IRQ_WAIT_EOI;
				else if (!irq_want)
					st_d.irq_st = FSI_IRQ_IDLE;
			end
			FSI_IRQ_WAIT_EOI:
			begin
				// held low until eoi so one service pass sees one edge
				if (eoi)
				begin
					st_d.irq_st = (|(st_d.pending & st_d.enable)) ? FSI_IRQ_ACTIVE
						: FSI_IRQ_IDLE;
				end
			end
			default:
			begin
				st_d.irq_st = FSI_IRQ_IDLE;
			end
		endcase

		// ======================================================================
		// read data, registered at the setup edge
		st_d.rdata = '0;
		if (apb_setup_rd)
		begin
			if (sel_pending)
				st_d.rdata = {16'h0000, st_q.pending};
			else if (sel_enable)
				st_d.rdata = {16'h0000, st_q.enable};
			else if (sel_bit)
				st_d.rdata = {31'h0, st_q.pending[bit_idx]};
			else if (sel_cmd)
				st_d.rdata = {29'h0, st_q.diag_req, st_q.offline_wait, st_q.offline};
		end
	end

	// ==========================================================================
	// registers
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			st_q         <= '0;
			st_q.pending <= FSI_PENDING_RST;
			st_q.enable  <= FSI_ENABLE_RST;
			st_q.gcmd    <= FSI_GCMD_RST;
			st_q.poweron <= 1'b1;
			st_q.irq_st  <= FSI_IRQ_IDLE;
		end
		else
			st_q <= st_d;
	end

	// zero wait states: the word a read returns is captured at the setup
	// edge, so an event landing during the access cycle is not in it;
	// it stays pending and shows on the next read.
	assign pready_out           = 1'b1;
	assign pslverr_out          = 1'b0;
	assign prdata_out           = st_q.rdata;
	assign offline_state_out    = st_q.offline;
	assign diag_swap_req_out    = st_q.diag_req;
	assign output_buf_clear_out = st_q.obuf_clear;
	assign global_cmd_cell_out  = st_q.gcmd;
	assign irq_out              = (st_q.irq_st == FSI_IRQ_ACTIVE);

endmodule

`default_nettype wire

// >>> dv/fsi_indication_assertions.sv
// fsi_indication_assertions: port-level checks of the indication unit.
// assumes it is bound to fsi_indication_unit and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// checker
module fsi_indication_checker
	import fsi_pkg::*;
(
	input wire logic        sys_clk_in,
	input wire logic        rstn_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [7:0]  paddr_in,
	input wire logic [31:0] prdata_out,
	input wire logic        pready_out,
	input wire logic        pslverr_out,
	input wire logic        request_busy_in,
	input wire logic        global_cmd_rx_in,
	input wire logic [7:0]  global_cmd_byte_in,
	input wire logic        master_leave_in,
	input wire logic        offline_state_out,
	input wire logic        output_buf_clear_out,
	input wire logic [7:0]  global_cmd_cell_out,
	input wire logic        irq_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_rd(logic [7:0] a);
		psel_in && penable_in && !pwrite_in && paddr_in == a;
	endsequence
	chk_pend_width: assert property (s_rd(FSI_PENDING_OFFS) |->
		(prdata_out & ~{16'h0, FSI_EV_IMPL_MASK}) == 32'h0) else $error("pending bits");
	chk_bit_read: assert property (psel_in && penable_in && !pwrite_in &&
		paddr_in[7:6] == 2'b01 |-> prdata_out[31:1] == 31'h0) else $error("bit read");
	chk_gcmd_store: assert property (global_cmd_rx_in &&
		global_cmd_byte_in != global_cmd_cell_out
		|=> global_cmd_cell_out == $past(global_cmd_byte_in)) else $error("gcmd cell");
	chk_leave_clear: assert property (master_leave_in |=> output_buf_clear_out)
		else $error("no clear");
	chk_clear_pulse: assert property (output_buf_clear_out |=> !output_buf_clear_out)
		else $error("clear too long");
	chk_offline_idle: assert property ($rose(offline_state_out) |-> !$past(request_busy_in))
		else $error("offline early");
	chk_irq_read: assert property (s_rd(FSI_PENDING_OFFS) ##0 irq_out |=> !irq_out)
		else $error("irq kept");
	chk_ack_taken: assert property (psel_in && penable_in && pwrite_in |->
		pready_out && !pslverr_out) else $error("ack refused");
endmodule

bind fsi_indication_unit fsi_indication_checker fsi_indication_checker_i (.sys_clk_in,
	.rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out, .pready_out,
	.pslverr_out, .request_busy_in, .global_cmd_rx_in, .global_cmd_byte_in,
	.master_leave_in, .offline_state_out, .output_buf_clear_out, .global_cmd_cell_out,
	.irq_out);
`default_nettype wire

// >>> dv/fsi_indication_unit_tb_top.sv
// fsi_indication_unit_tb_top: APB-driven self-checking bench.
// assumes a zero-wait slave; the 10 ms tick is too long to run here.
`timescale 1ns/1ps
`default_nettype none
module fsi_indication_unit_tb_top
	import fsi_pkg::*;
	;
	logic        sys_clk_in, rstn_in, psel_in, penable_in, pwrite_in;
	logic        request_busy_in, offline_req_in, pready_out, pslverr_out;
	logic        offline_state_out, diag_swap_req_out, output_buf_clear_out, irq_out;
	logic [7:0]  paddr_in, global_cmd_byte_in, global_cmd_cell_out;
	logic [31:0] pwdata_in, prdata_out;
	logic [9:0]  ev;
	int          err_total, tests_run;
	localparam int BP [10] = '{FSI_EV_EXCHANGE, FSI_EV_RATE, FSI_EV_WATCHDOG,
		FSI_EV_GLOBAL_CMD, FSI_EV_ADDRESS, FSI_EV_CONFIG, FSI_EV_PARAM,
		FSI_EV_OUTPUT, FSI_EV_DIAG, FSI_EV_OUTPUT};

	fsi_indication_unit fsi_indication_unit_i (.sys_clk_in, .rstn_in, .psel_in,
		.penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in(4'hf), .prdata_out,
		.pready_out, .pslverr_out, .exchange_state_in(ev[0]), .offline_req_in,
		.request_busy_in, .rate_search_in(!ev[1]), .rate_valid_in(1'b1),
		.wd_expired_in(ev[2]), .master_controlled_wd_state_in(1'b1),
		.global_cmd_rx_in(ev[3]), .global_cmd_byte_in, .address_msg_stored_in(ev[4]),
		.config_msg_stored_in(ev[5]), .param_msg_stored_in(ev[6]),
		.output_data_stored_in(ev[7]), .diag_swap_done_in(ev[8]),
		.master_leave_in(ev[9]), .offline_state_out, .diag_swap_req_out,
		.output_buf_clear_out, .global_cmd_cell_out, .irq_out);

	initial
	begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	// every driver task starts on a rising edge, so back-to-back calls never collide
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge sys_clk_in);
		{psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, w, a, d};
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		do @(posedge sys_clk_in); while (pready_out !== 1'b1);
		r = prdata_out;
		{psel_in, penable_in} <= 2'b00;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask

	task automatic pulse(input int i, input logic [7:0] b);
		@(posedge sys_clk_in);
		ev[i] <= 1'b1;
		global_cmd_byte_in <= b;
		@(posedge sys_clk_in);
		ev[i] <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		{rstn_in, psel_in, penable_in, pwrite_in, request_busy_in, offline_req_in} = 6'h0;
		{paddr_in, global_cmd_byte_in, pwdata_in, ev} = '0;
		{err_total, tests_run} = '0;
		repeat (2) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		rc(FSI_ENABLE_OFFS, 32'h0);
		rc(FSI_PENDING_OFFS, 32'h1 << FSI_EV_OUTPUT);
		rc(FSI_BIT_OFFS + 8'(4 * FSI_EV_OUTPUT), 32'h1);
		rc(FSI_BIT_OFFS, 32'h0);
		wr(FSI_BITACK_OFFS + 8'(4 * FSI_EV_OUTPUT), 32'h1);
		rc(FSI_PENDING_OFFS, 32'h0);
		rc(8'h30, 32'h0);
		wr(FSI_CMD_OFFS, 32'h2);
		@(negedge sys_clk_in);
		chk(32'(diag_swap_req_out), 32'h1);
		for (int i = 0; i < 10; i++)
		begin
			pulse(i, 8'h10 + 8'(i));
			rc(FSI_PENDING_OFFS, 32'h1 << BP[i]);
			wr(FSI_ACK_OFFS, 32'h1 << BP[i]);
		end
		chk(32'(global_cmd_cell_out), 32'h13);
		pulse(3, 8'h13);
		rc(FSI_PENDING_OFFS, 32'h0);
		wr(FSI_ENABLE_OFFS, 32'hffffffff);
		rc(FSI_ENABLE_OFFS, 32'(FSI_EV_IMPL_MASK));
		wr(FSI_ENABLE_OFFS, 32'h1 << FSI_EV_ADDRESS);
		pulse(5, 8'h13);
		chk(32'(irq_out), 32'h0);
		pulse(4, 8'h13);
		chk(32'(irq_out), 32'h1);
		rc(FSI_PENDING_OFFS, 32'h600);
		@(negedge sys_clk_in);
		chk(32'(irq_out), 32'h0);
		wr(FSI_EOI_OFFS, 32'h0);
		repeat (2) @(negedge sys_clk_in);
		chk(32'(irq_out), 32'h1);
		wr(FSI_ACK_OFFS, 32'h600);
		wr(FSI_EOI_OFFS, 32'h0);
		repeat (2) @(negedge sys_clk_in);
		chk(32'(irq_out), 32'h0);
		@(posedge sys_clk_in);
		{request_busy_in, offline_req_in} <= 2'b11;
		@(posedge sys_clk_in);
		offline_req_in <= 1'b0;
		repeat (4) @(negedge sys_clk_in);
		chk(32'(offline_state_out), 32'h0);
		@(posedge sys_clk_in);
		request_busy_in <= 1'b0;
		repeat (3) @(negedge sys_clk_in);
		chk(32'(offline_state_out), 32'h1);
		rc(FSI_PENDING_OFFS, 32'h1 << FSI_EV_OFFLINE);
		test_done();
	end

	initial
	begin
		repeat (5000) @(posedge sys_clk_in);
		err_total++;
		test_done();
	end
endmodule
`default_nettype wire
